// *** design/irq_ctrl.sv ***
// two-level vectored interrupt controller with apb register slave
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

module irq_ctrl
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // external interrupt pins, active low
  input  wire logic [5:0]                ext_irq_pin,
  // peripheral flag set pulses and power fail level
  input  wire irq_ctrl_pkg::periph_evt_s periph_evt,
  input  wire logic                      power_fail_irq,
  // processor core sequencer
  input  wire irq_ctrl_pkg::core_stat_s  core_stat,
  input  wire logic [15:0]               stack_rd_data,
  output irq_ctrl_pkg::core_cmd_s        core_cmd
);

  parameter logic [15:0] PF_VECTOR = 16'h0033;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // index of lowest set bit, natural order
  function automatic logic [3:0] first_set(input logic [11:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 11; i >= 0; i--)
    begin
      if (v[i])
        idx = 4'(i);
    end
    return idx;
  endfunction

  // vector address of a source
  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    logic [15:0] v;
    unique case (idx)
      4'h0:    v = irq_ctrl_pkg::VEC_EXT0;
      4'h1:    v = irq_ctrl_pkg::VEC_T0;
      4'h2:    v = irq_ctrl_pkg::VEC_EXT1;
      4'h3:    v = irq_ctrl_pkg::VEC_T1;
      4'h4:    v = irq_ctrl_pkg::VEC_U0;
      4'h5:    v = irq_ctrl_pkg::VEC_T2;
      4'h6:    v = irq_ctrl_pkg::VEC_U1;
      4'h7:    v = irq_ctrl_pkg::VEC_EXT2;
      4'h8:    v = irq_ctrl_pkg::VEC_EXT3;
      4'h9:    v = irq_ctrl_pkg::VEC_EXT4;
      4'hA:    v = irq_ctrl_pkg::VEC_EXT5;
      4'hB:    v = irq_ctrl_pkg::VEC_WDOG;
      default: v = PF_VECTOR;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_int_n;
  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;

  // two-stage reset release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_int_n = rst_sync_q[1];

  // two-flop pin synchroniser, idle high
  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      pin_meta_q <= 6'h3F;
      pin_sync_q <= 6'h3F;
    end
    else
    begin
      pin_meta_q <= ext_irq_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // machine cycle phase and pin sampling
  // ----------------------------------------------------------------
  logic [1:0] phase_q;
  logic [5:0] pin_smp_q;
  logic       smp_now;
  logic       poll_now;
  logic [5:0] pin_fell;

  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      phase_q <= 2'h0;
    else
      phase_q <= phase_q + 2'h1;
  end

  assign smp_now  = (phase_q == irq_ctrl_pkg::PHASE_SAMPLE);
  assign poll_now = (phase_q == irq_ctrl_pkg::PHASE_POLL);

  // last machine-cycle sample of each pin
  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      pin_smp_q <= 6'h3F;
    else if (smp_now)
      pin_smp_q <= pin_sync_q;
  end

  // high in previous sample, low now; all six pins
  assign pin_fell = {6{smp_now}} & pin_smp_q & ~pin_sync_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [12:0] enable_q;
  logic [11:0] level_q;
  logic [14:0] flags_q;
  logic [14:0] flags_d;
  logic [1:0]  in_svc_q;     // bit1 high level, bit0 low level
  logic [3:0]  last_src_q;

  logic        wr_en;
  logic        rd_en;
  logic        addr_hit;
  logic        ext0_level;
  logic        ext1_level;
  logic        gate;
  logic [3:0]  hw_clr_sel;

  assign wr_en      = psel && penable && pwrite;
  assign rd_en      = psel && penable && !pwrite;
  assign addr_hit   = (paddr == irq_ctrl_pkg::ADDR_CTRL)   || (paddr == irq_ctrl_pkg::ADDR_ENABLE)
                   || (paddr == irq_ctrl_pkg::ADDR_LEVEL)  || (paddr == irq_ctrl_pkg::ADDR_FLAGS)
                   || (paddr == irq_ctrl_pkg::ADDR_STATUS);
  assign ext0_level = ctrl_q[irq_ctrl_pkg::CTRL_EXT0_TYPE];
  assign ext1_level = ctrl_q[irq_ctrl_pkg::CTRL_EXT1_TYPE];
  assign gate       = ctrl_q[irq_ctrl_pkg::CTRL_GATE];
  assign hw_clr_sel = ctrl_q[irq_ctrl_pkg::CTRL_HWCLR_LSB +: 4];

  // zero-wait slave, unmapped address errors
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  // read data mux
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_en)
    begin
      unique case (paddr)
        irq_ctrl_pkg::ADDR_CTRL:   prdata = {24'h000000, ctrl_q};
        irq_ctrl_pkg::ADDR_ENABLE: prdata = {19'h00000, enable_q};
        irq_ctrl_pkg::ADDR_LEVEL:  prdata = {20'h00000, level_q};
        irq_ctrl_pkg::ADDR_FLAGS:  prdata = {17'h00000, flags_q};
        irq_ctrl_pkg::ADDR_STATUS: prdata = {23'h000000, core_cmd.busy, last_src_q,
                                             2'h0, in_svc_q};
        default:                   prdata = 32'h0000_0000;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      ctrl_q   <= irq_ctrl_pkg::CTRL_RST;
      enable_q <= irq_ctrl_pkg::ENABLE_RST;
      level_q  <= irq_ctrl_pkg::LEVEL_RST;
    end
    else if (wr_en)
    begin
      if (paddr == irq_ctrl_pkg::ADDR_CTRL)
        ctrl_q <= pwdata[7:0];
      if (paddr == irq_ctrl_pkg::ADDR_ENABLE)
        enable_q <= pwdata[12:0];
      if (paddr == irq_ctrl_pkg::ADDR_LEVEL)
        level_q <= pwdata[11:0];
    end
  end

  // ----------------------------------------------------------------
  // request resolution
  // ----------------------------------------------------------------
  logic [11:0] req;
  logic [11:0] req_en;
  logic [11:0] hi_req;
  logic [11:0] lo_req;
  logic        pf_req;
  logic        hi_ok;
  logic        lo_ok;
  logic        any_win;
  logic [3:0]  win_src;
  logic        win_high;
  logic        call_start;
  irq_ctrl_pkg::seq_state_e state_q;

  // flags into requests, natural order
  assign req = {flags_q[irq_ctrl_pkg::FLG_WDOG],
                flags_q[irq_ctrl_pkg::FLG_EXT2 +: 4],
                flags_q[irq_ctrl_pkg::FLG_U1RX] | flags_q[irq_ctrl_pkg::FLG_U1TX],
                flags_q[irq_ctrl_pkg::FLG_T2OV] | flags_q[irq_ctrl_pkg::FLG_T2EX],
                flags_q[irq_ctrl_pkg::FLG_U0RX] | flags_q[irq_ctrl_pkg::FLG_U0TX],
                flags_q[irq_ctrl_pkg::FLG_T1],
                flags_q[irq_ctrl_pkg::FLG_EXT1],
                flags_q[irq_ctrl_pkg::FLG_T0],
                flags_q[irq_ctrl_pkg::FLG_EXT0]};

  assign req_en   = req & enable_q[11:0] & {12{gate}};
  assign pf_req   = power_fail_irq & enable_q[irq_ctrl_pkg::EN_POWER_FAIL];
  assign hi_req   = req_en & level_q;
  assign lo_req   = req_en & ~level_q;
  // equal or higher level in service blocks the call
  assign hi_ok    = !in_svc_q[1] && (pf_req || (hi_req != 12'h000));
  assign lo_ok    = !in_svc_q[1] && !in_svc_q[0] && (lo_req != 12'h000);
  assign any_win  = hi_ok || lo_ok;
  assign win_high = hi_ok;
  assign win_src  = pf_req && hi_ok ? irq_ctrl_pkg::SRC_PF
                  : hi_ok ? first_set(hi_req) : first_set(lo_req);

  // fresh poll every machine cycle, nothing held over
  assign call_start = poll_now && (state_q == irq_ctrl_pkg::ST_IDLE) && any_win
                   && core_stat.last_cycle && !core_stat.no_irq_instr
                   && !core_stat.return_from_irq && !core_stat.ret;

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  logic [14:0] flag_set;
  logic [14:0] flag_clr;
  logic [14:0] flag_base;
  logic        hw_ext0_clr;
  logic        hw_ext1_clr;
  logic [3:0]  hw_ext25_clr;

  assign hw_ext0_clr  = call_start && (win_src == irq_ctrl_pkg::SRC_EXT0) && !ext0_level;
  assign hw_ext1_clr  = call_start && (win_src == irq_ctrl_pkg::SRC_EXT1) && !ext1_level;
  assign hw_ext25_clr = {4{call_start && (win_src >= irq_ctrl_pkg::SRC_EXT2)
                           && (win_src <= irq_ctrl_pkg::SRC_EXT5)}}
                      & hw_clr_sel
                      & (4'h1 << 2'(win_src - irq_ctrl_pkg::SRC_EXT2));

  // hardware sets: pin edges or low level, peripheral pulses
  assign flag_set = {periph_evt.u1_tx, periph_evt.u1_rx, periph_evt.u0_tx, periph_evt.u0_rx,
                     periph_evt.wdog_timeout,
                     periph_evt.t2_ext, periph_evt.t2_ovf,
                     periph_evt.t1_ovf, periph_evt.t0_ovf,
                     pin_fell[5:2],
                     ext1_level ? (smp_now && !pin_sync_q[1]) : pin_fell[1],
                     ext0_level ? (smp_now && !pin_sync_q[0]) : pin_fell[0]};

  // hardware clears: call acknowledge, level pin released
  assign flag_clr = {7'h00,
                     call_start && (win_src == irq_ctrl_pkg::SRC_T1),
                     call_start && (win_src == irq_ctrl_pkg::SRC_T0),
                     hw_ext25_clr,
                     hw_ext1_clr || (ext1_level && smp_now && pin_sync_q[1]),
                     hw_ext0_clr || (ext0_level && smp_now && pin_sync_q[0])};

  // software write, then clears, set wins last
  assign flag_base = (wr_en && (paddr == irq_ctrl_pkg::ADDR_FLAGS)) ? pwdata[14:0] : flags_q;
  assign flags_d   = (flag_base & ~flag_clr) | flag_set;

  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      flags_q <= irq_ctrl_pkg::FLAGS_RST;
    else
      flags_q <= flags_d;
  end

  // ----------------------------------------------------------------
  // call and return sequencer
  // ----------------------------------------------------------------
  logic [4:0]  call_cnt_q;
  logic [15:0] call_vec_q;
  logic        return_from_irq_seen;
  logic        ret_seen;
  logic        call_done;

  assign return_from_irq_seen = (state_q == irq_ctrl_pkg::ST_IDLE) && core_stat.return_from_irq;
  assign ret_seen  = (state_q == irq_ctrl_pkg::ST_IDLE) && core_stat.ret;
  assign call_done = (state_q == irq_ctrl_pkg::ST_CALL)
                  && (call_cnt_q == 5'(irq_ctrl_pkg::CALL_CLKS - 1));

  // sequencer state
  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      state_q <= irq_ctrl_pkg::ST_IDLE;
    else
    begin
      unique case (state_q)
        irq_ctrl_pkg::ST_IDLE: state_q <= call_start ? irq_ctrl_pkg::ST_CALL
          : (return_from_irq_seen || ret_seen) ? irq_ctrl_pkg::ST_RET : irq_ctrl_pkg::ST_IDLE;
        irq_ctrl_pkg::ST_CALL: state_q <= call_done ? irq_ctrl_pkg::ST_IDLE : irq_ctrl_pkg::ST_CALL;
        irq_ctrl_pkg::ST_RET:  state_q <= irq_ctrl_pkg::ST_IDLE;
        default:               state_q <= irq_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // call length counter and captured vector
  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      call_cnt_q <= 5'h00;
      call_vec_q <= 16'h0000;
      last_src_q <= 4'h0;
    end
    else if (call_start)
    begin
      call_cnt_q <= 5'h00;
      call_vec_q <= vec_of(win_src);
      last_src_q <= win_src;
    end
    else if (state_q == irq_ctrl_pkg::ST_CALL)
      call_cnt_q <= call_cnt_q + 5'h01;
  end

  // in-service bits per level
  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      in_svc_q <= 2'h0;
    else if (call_start)
      in_svc_q <= in_svc_q | (win_high ? 2'h2 : 2'h1);
    else if (return_from_irq_seen)
      in_svc_q <= in_svc_q[1] ? {1'b0, in_svc_q[0]} : 2'h0;
  end

  // core commands from flops
  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      core_cmd <= '0;
    else
    begin
      core_cmd.busy          <= call_start || (state_q == irq_ctrl_pkg::ST_CALL && !call_done)
                             || return_from_irq_seen || ret_seen;
      core_cmd.stack_push    <= call_start;
      core_cmd.stack_pop     <= return_from_irq_seen || ret_seen;
      core_cmd.pc_load       <= call_done || (state_q == irq_ctrl_pkg::ST_RET);
      if (call_start)
        core_cmd.stack_wr_data <= core_stat.pc;
      if (call_done)
        core_cmd.pc_value <= call_vec_q;
      else if (state_q == irq_ctrl_pkg::ST_RET)
        core_cmd.pc_value <= stack_rd_data;
    end
  end

endmodule

`default_nettype wire

// *** design/irq_ctrl_pkg.sv ***
// constants, register map and carrier types of the vectored interrupt controller
package irq_ctrl_pkg;

  // ----------------------------------------------------------------
  // clock and machine-cycle timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned CLK_PER_MCYC   = 4;
  localparam int unsigned CALL_MCYC      = 4;
  localparam int unsigned CALL_CLKS      = CALL_MCYC * CLK_PER_MCYC;
  localparam logic [1:0]  PHASE_SAMPLE   = 2'h2;  // third clock phase
  localparam logic [1:0]  PHASE_POLL     = 2'h1;
  localparam logic [1:0]  PHASE_LAST     = 2'h3;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_LEVEL  = 8'h08;
  localparam logic [7:0] ADDR_FLAGS  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ctrl register fields, and the power fail bit of the enable register
  localparam int unsigned CTRL_EXT0_TYPE = 0;
  localparam int unsigned CTRL_EXT1_TYPE = 1;
  localparam int unsigned CTRL_GATE      = 2;
  localparam int unsigned CTRL_HWCLR_LSB = 4;
  localparam int unsigned EN_POWER_FAIL  = 12;

  // flag register fields
  localparam int unsigned FLG_EXT0  = 0;
  localparam int unsigned FLG_EXT1  = 1;
  localparam int unsigned FLG_EXT2  = 2;
  localparam int unsigned FLG_T0    = 6;
  localparam int unsigned FLG_T1    = 7;
  localparam int unsigned FLG_T2OV  = 8;
  localparam int unsigned FLG_T2EX  = 9;
  localparam int unsigned FLG_WDOG  = 10;
  localparam int unsigned FLG_U0RX  = 11;
  localparam int unsigned FLG_U0TX  = 12;
  localparam int unsigned FLG_U1RX  = 13;
  localparam int unsigned FLG_U1TX  = 14;
  localparam int unsigned NUM_FLAGS = 15;

  // reset values
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [12:0] ENABLE_RST = 13'h0000;
  localparam logic [11:0] LEVEL_RST  = 12'h000;
  localparam logic [14:0] FLAGS_RST  = 15'h0000;

  // source index in natural order, 0 is served first
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_T0   = 4'h1;
  localparam logic [3:0] SRC_EXT1 = 4'h2;
  localparam logic [3:0] SRC_T1   = 4'h3;
  localparam logic [3:0] SRC_EXT2 = 4'h7;
  localparam logic [3:0] SRC_EXT5 = 4'hA;
  localparam logic [3:0] SRC_PF   = 4'hC;

  // vector addresses
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_T0   = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_T1   = 16'h001B;
  localparam logic [15:0] VEC_U0   = 16'h0023;
  localparam logic [15:0] VEC_T2   = 16'h002B;
  localparam logic [15:0] VEC_U1   = 16'h003B;
  localparam logic [15:0] VEC_EXT2 = 16'h0043;
  localparam logic [15:0] VEC_EXT3 = 16'h004B;
  localparam logic [15:0] VEC_EXT4 = 16'h0053;
  localparam logic [15:0] VEC_EXT5 = 16'h005B;
  localparam logic [15:0] VEC_WDOG = 16'h0063;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic t0_ovf;
    logic t1_ovf;
    logic t2_ovf;
    logic t2_ext;
    logic wdog_timeout;
    logic u0_rx;
    logic u0_tx;
    logic u1_rx;
    logic u1_tx;
  } periph_evt_s;

  typedef struct packed {
    logic        last_cycle;
    logic        no_irq_instr;
    logic        return_from_irq;
    logic        ret;
    logic [15:0] pc;
  } core_stat_s;

  typedef struct packed {
    logic        busy;
    logic        stack_push;
    logic        stack_pop;
    logic        pc_load;
    logic [15:0] pc_value;
    logic [15:0] stack_wr_data;
  } core_cmd_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CALL = 3'b010,
    ST_RET  = 3'b100
  } seq_state_e;

endpackage

// *** tb/irq_ctrl_props.sv ***
// concurrent checks on the interrupt controller ports
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_props #(parameter logic [15:0] PF_VECTOR = 16'h0033)
(
  // clock and reset
  input wire logic                     clk,
  input wire logic                     rst_n,
  // apb
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pslverr,
  // core sequencer
  input wire irq_ctrl_pkg::core_stat_s core_stat,
  input wire irq_ctrl_pkg::core_cmd_s  core_cmd
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // vector call and return sequencing
  // ----------------------------------------------------------------
  property p_push_pc;
    core_cmd.stack_push |-> core_cmd.stack_wr_data == $past(core_stat.pc);
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("pushed word not pc");
  property p_call_gate;
    core_cmd.stack_push |-> $past(core_stat.last_cycle) && !$past(core_stat.return_from_irq);
  endproperty
  a_call_gate: assert property (p_call_gate) else $error("call not allowed");
  property p_call_len;
    $rose(core_cmd.stack_push) |-> ##16 core_cmd.pc_load;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call length wrong");
  property p_busy;
    $rose(core_cmd.stack_push) |-> core_cmd.busy [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("busy dropped in call");
  property p_vector;
    core_cmd.pc_load && !$past(core_cmd.stack_pop) |-> (core_cmd.pc_value[2:0] == 3'h3
      && core_cmd.pc_value < 16'h0064) || core_cmd.pc_value == PF_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector");
  property p_return_from_irq_pop;
    core_stat.return_from_irq && !core_cmd.busy |=> core_cmd.stack_pop;
  endproperty
  a_return_from_irq_pop: assert property (p_return_from_irq_pop) else $error("no pop on return");
  property p_pop_load;
    core_cmd.stack_pop |=> core_cmd.pc_load;
  endproperty
  a_pop_load: assert property (p_pop_load) else $error("no pc load after pop");
  property p_load_end;
    core_cmd.pc_load |=> !core_cmd.busy;
  endproperty
  a_load_end: assert property (p_load_end) else $error("busy after pc load");
  // main scenarios reached
  c_call: cover property (core_cmd.stack_push);
  c_ret: cover property (core_cmd.stack_pop);
  c_err: cover property (psel && penable && pslverr);
endmodule
bind irq_ctrl irq_ctrl_props #(.PF_VECTOR(PF_VECTOR)) props (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pslverr(pslverr), .core_stat(core_stat), .core_cmd(core_cmd));
`default_nettype wire

// *** tb/core_model.sv ***
// core sequencer and one-deep stack facing the controller
`timescale 1ns/10ps
`default_nettype none
module core_model
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // return request from the bench
  input  wire logic                    return_from_irq_req,
  // controller side
  input  wire irq_ctrl_pkg::core_cmd_s core_cmd,
  output irq_ctrl_pkg::core_stat_s     core_stat,
  output logic [15:0]                  stack_rd_data
);
  logic [15:0] ret_q;
  logic [2:0]  cnt_q;
  logic        pop_q;
  // stack word, scrambled outside its read window
  assign stack_rd_data = (core_cmd.stack_pop || pop_q) ? ret_q : ~ret_q;
  // last cycle only half the time, so some polls are refused
  assign core_stat = {cnt_q[2], 1'b0, return_from_irq_req, 1'b0, 16'h1234};
  // stack word and instruction phase counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ret_q <= 16'h0000;
      cnt_q <= 3'h0;
      pop_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 3'h1;
      pop_q <= core_cmd.stack_pop;
      if (core_cmd.stack_push)
        ret_q <= core_cmd.stack_wr_data;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_irq_ctrl.sv ***
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module tb_irq_ctrl;
  logic                     clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [7:0]               paddr = 8'h00;
  logic [31:0]              pwdata = 32'h0;
  logic [5:0]               pins = 6'h3F;
  logic                     return_from_irq_req = 1'b0;
  logic                     pf = 1'b0;
  irq_ctrl_pkg::periph_evt_s evt = '0;
  logic                     pready;
  logic [31:0]              prdata;
  logic                     pslverr;
  irq_ctrl_pkg::core_stat_s cstat;
  irq_ctrl_pkg::core_cmd_s  ccmd;
  logic [15:0]              srd;
  logic [31:0]              rd;
  logic                     err;
  logic [14:0]              pend;
  logic [14:0]              msk [12] = '{15'h0001, 15'h0040, 15'h0002, 15'h0080, 15'h1800,
    15'h0300, 15'h6000, 15'h0004, 15'h0008, 15'h0010, 15'h0020, 15'h0400};
  int                       failures = 0;
  int                       checks_done = 0;
  int                       n;
  // 25 MHz clock
  always #20 clk = ~clk;
  irq_ctrl DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_irq_pin(pins), .periph_evt(evt), .power_fail_irq(pf), .core_stat(cstat),
    .stack_rd_data(srd), .core_cmd(ccmd));
  core_model partner (.clk(clk), .rst_n(rst_n), .return_from_irq_req(return_from_irq_req), .core_cmd(ccmd),
    .core_stat(cstat), .stack_rd_data(srd));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo();
    failures++;
    final_report();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++k < 20);
    if (pready !== 1'b1)
      tmo();
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wait_load(input logic [15:0] exp);
    int k;
    k = 0;
    do @(posedge clk); while (ccmd.pc_load !== 1'b1 && ++k < 200);
    if (ccmd.pc_load !== 1'b1)
      tmo();
    chk({16'h0, ccmd.pc_value}, {16'h0, exp});
  endtask
  task automatic ret_irq();
    @(posedge clk);
    return_from_irq_req <= 1'b1;
    @(posedge clk);
    return_from_irq_req <= 1'b0;
    wait_load(16'h1234);
  endtask
  task automatic quiet();
    int k;
    k = 0;
    repeat (40) @(posedge clk) k += (ccmd.pc_load === 1'b1);
    chk(k, 0);
  endtask
  // test sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (n = 0; n < 5; n++)
    begin
      apb(1'b0, 8'(4 * n + (n / 4) * 4), 32'h0);
      chk({err, rd[30:0]}, n < 4 ? 32'h0 : 32'h80000000);
    end
    $display("reset test done");
    apb(1'b1, 8'h04, 32'h0FFF);
    apb(1'b1, 8'h0C, 32'h7FFF);
    apb(1'b1, 8'h00, 32'h04);
    pend = 15'h7FFF;
    for (n = 0; n < 12; n++)
    begin
      wait_load(16'h0003 + 16'(8 * (n + (n > 5))));
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, {17'h0, pend & ~(n < 4 ? msk[n] : 15'h0)});
      pend = pend & ~msk[n];
      apb(1'b1, 8'h0C, {17'h0, pend});
      ret_irq();
    end
    $display("order test done");
    apb(1'b1, 8'h00, 32'h00);
    apb(1'b1, 8'h08, 32'h0800);
    apb(1'b1, 8'h0C, 32'h0401);
    quiet();
    apb(1'b1, 8'h00, 32'h04);
    wait_load(16'h0063);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0000_00B2);
    apb(1'b1, 8'h0C, 32'h0001);
    quiet();
    ret_irq();
    wait_load(16'h0003);
    ret_irq();
    $display("level test done");
    apb(1'b1, 8'h08, 32'h0);
    for (n = 0; n < 2; n++)
    begin
      apb(1'b1, 8'h00, n ? 32'h06 : 32'h14);
      pins <= n ? 6'h3D : 6'h3B;
      wait_load(n ? 16'h0013 : 16'h0043);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, n ? 32'h0002 : 32'h0);
      pins <= 6'h3F;
      apb(1'b1, 8'h0C, 32'h0);
      ret_irq();
    end
    $display("pin test done");
    apb(1'b1, 8'h00, 32'h00);
    evt <= '1;
    @(posedge clk);
    evt <= '0;
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h7FC0);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h04, 32'h1000);
    pf <= 1'b1;
    wait_load(16'h0033);
    pf <= 1'b0;
    ret_irq();
    $display("event test done");
    final_report();
  end
endmodule
`default_nettype wire
